// ===== include/flash_led_pkg.sv
package flash_led_pkg;

    // ------------------------------------------------------------
    // register image
    // ------------------------------------------------------------
    localparam int REG_W              = 8;
    localparam int NUM_CHANNELS       = 3;
    localparam logic [7:0] REG_CLEAR  = 8'h00;

    // control_reg_one field positions
    localparam int C1_MODE_HI         = 7;
    localparam int C1_MODE_LO         = 6;
    localparam int C1_RETAIN          = 5;
    localparam int C1_TMO_HI          = 1;
    localparam int C1_TMO_LO          = 0;
    localparam logic [1:0] MODE_FLASH = 2'h3;

    // control_reg_two field position
    localparam int C2_VLIM_HI         = 7;
    localparam int C2_VLIM_LO         = 5;

    // ------------------------------------------------------------
    // voltages in millivolts
    // ------------------------------------------------------------
    localparam int VOLT_W                  = 13;
    localparam logic [12:0] READY_MARGIN_MV = 13'h0064;  // 100 mV
    localparam logic [12:0] TORCH_LIMIT_MV  = 13'h1194;  // 4500 mV
    localparam logic [12:0] FLASH_BASE_MV   = 13'h1068;  // code 0 limit, plain default
    localparam logic [12:0] FLASH_STEP_MV   = 13'h0032;  // per code step, plain default

    // ------------------------------------------------------------
    // flash timeout, cycles at 200 MHz
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS      = 5000;
    localparam int TMO_MS_0           = 50;
    localparam int TMO_MS_1           = 110;
    localparam int TMO_MS_2           = 220;
    localparam int TMO_MS_3           = 400;
    localparam int TMO_W              = 27;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl_one;
        logic [7:0] ctrl_two;
        logic [7:0] flash_cur;
        logic [7:0] torch_cur;
    } reg_image_t;

    typedef enum logic [1:0] {
        REG_SEL_ONE   = 2'h0,
        REG_SEL_TWO   = 2'h1,
        REG_SEL_FLASH = 2'h2,
        REG_SEL_TORCH = 2'h3
    } reg_sel_t;

    typedef struct packed {
        logic     wr;
        reg_sel_t sel;
        logic [7:0] data;
    } reg_wr_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_FLASH = 2'b10
    } flash_state_t;

endpackage : flash_led_pkg

// ===== hdl/flash_led_driver_control.sv
`timescale 1ns/1ps
// Behaviour
// - ready high within 100mV of limit
// - flash limit from ctrl two bits 7:5
// - torch limit fixed at 4.50V
// - shutdown low forces LED drive off
// - shutdown, retain clear: registers cleared
// - shutdown, retain set: registers kept
// - flash mode plus trigger: one timeout
// - timeout length from ctrl one bits 1:0
// - sink current from mode-matching setting
// - short LED detect switches current off
// - registers written and read back
module flash_led_driver_control (
    input  wire logic                                clk_sys,
    input  wire logic                                rst_n,
    input  wire logic                                shutdown_n,
    input  wire logic                                flash_trigger,
    input  wire flash_led_pkg::reg_wr_t              reg_wr,
    input  wire flash_led_pkg::reg_sel_t             reg_rd_sel,
    output logic [7:0]                               reg_rd_data,
    input  wire logic [12:0]                         vout_mv,
    input  wire logic [12:0]                         led_mv,
    input  wire logic                                torch_en,
    output logic                                     supply_ready_flag,
    output logic [12:0]                              output_voltage_limit,
    output logic [flash_led_pkg::NUM_CHANNELS-1:0]   led_on,
    output logic [7:0]                               led_sink_current,
    output logic                                     flash_active,
    output logic                                     short_led_flag
);
    import flash_led_pkg::*;

    localparam logic [TMO_W-1:0] TMO_CYC_0 = TMO_W'(64'(TMO_MS_0) * 1000000000 / CLK_PERIOD_PS);
    localparam logic [TMO_W-1:0] TMO_CYC_1 = TMO_W'(64'(TMO_MS_1) * 1000000000 / CLK_PERIOD_PS);
    localparam logic [TMO_W-1:0] TMO_CYC_2 = TMO_W'(64'(TMO_MS_2) * 1000000000 / CLK_PERIOD_PS);
    localparam logic [TMO_W-1:0] TMO_CYC_3 = TMO_W'(64'(TMO_MS_3) * 1000000000 / CLK_PERIOD_PS);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    reg_image_t regs_q, regs_d;

    always_comb begin
        regs_d = regs_q;
        if (!shutdown_n) begin
            if (!regs_q.ctrl_one[C1_RETAIN]) begin
                regs_d = '0;
            end
        end else if (reg_wr.wr) begin
            unique case (reg_wr.sel)
                REG_SEL_ONE:   regs_d.ctrl_one  = reg_wr.data;
                REG_SEL_TWO:   regs_d.ctrl_two  = reg_wr.data;
                REG_SEL_FLASH: regs_d.flash_cur = reg_wr.data;
                REG_SEL_TORCH: regs_d.torch_cur = reg_wr.data;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regs_q <= '0;
        end else begin
            regs_q <= regs_d;
        end
    end

    logic [7:0] rd_d;
    always_comb begin
        unique case (reg_rd_sel)
            REG_SEL_ONE:   rd_d = regs_q.ctrl_one;
            REG_SEL_TWO:   rd_d = regs_q.ctrl_two;
            REG_SEL_FLASH: rd_d = regs_q.flash_cur;
            REG_SEL_TORCH: rd_d = regs_q.torch_cur;
        endcase
    end

    // ------------------------------------------------------------
    // trigger synchroniser and edge
    // ------------------------------------------------------------
    // first stage read only by the second stage
    logic trig_s1_q, trig_s2_q, trig_s3_q;
    logic trig_s1_d, trig_s2_d, trig_s3_d;
    always_comb begin
        trig_s1_d = flash_trigger;
        trig_s2_d = trig_s1_q;
        trig_s3_d = trig_s2_q;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_s3_q <= 1'b0;
        end else begin
            trig_s1_q <= trig_s1_d;
            trig_s2_q <= trig_s2_d;
            trig_s3_q <= trig_s3_d;
        end
    end
    logic trig_rise;
    assign trig_rise = trig_s2_q & ~trig_s3_q;

    // ------------------------------------------------------------
    // flash timeout
    // ------------------------------------------------------------
    logic [1:0] mode_bits;
    logic       flash_mode;
    assign mode_bits  = regs_q.ctrl_one[C1_MODE_HI:C1_MODE_LO];
    assign flash_mode = (mode_bits == MODE_FLASH);

    logic [TMO_W-1:0] tmo_len;
    always_comb begin
        unique case (regs_q.ctrl_one[C1_TMO_HI:C1_TMO_LO])
            2'h0: tmo_len = TMO_CYC_0;
            2'h1: tmo_len = TMO_CYC_1;
            2'h2: tmo_len = TMO_CYC_2;
            2'h3: tmo_len = TMO_CYC_3;
        endcase
    end

    flash_state_t     st_q, st_d;
    logic [TMO_W-1:0] cnt_q, cnt_d;

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        unique case (st_q)
            ST_IDLE: begin
                // a level held high never retriggers: only a fresh edge starts
                if (shutdown_n && flash_mode && trig_rise) begin
                    st_d  = ST_FLASH;
                    cnt_d = tmo_len;
                end
            end
            ST_FLASH: begin
                if (!shutdown_n || cnt_q == TMO_W'(1)) begin
                    st_d  = ST_IDLE;
                    cnt_d = '0;
                end else begin
                    cnt_d = cnt_q - TMO_W'(1);
                end
            end
            default: begin
                st_d  = ST_IDLE;
                cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= ST_IDLE;
            cnt_q <= '0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------
    // limit, ready, short protect, sinks
    // ------------------------------------------------------------
    logic [12:0] limit;
    always_comb begin
        if (flash_mode) begin
            limit = FLASH_BASE_MV + 13'(FLASH_STEP_MV *
                    13'(regs_q.ctrl_two[C2_VLIM_HI:C2_VLIM_LO]));
        end else begin
            limit = TORCH_LIMIT_MV;
        end
    end

    logic ready_d, short_d, drive_d;
    logic [7:0] cur_d;
    always_comb begin
        // one spare bit so a reading near full scale cannot wrap below the limit
        ready_d = shutdown_n &&
                  ({1'b0, vout_mv} + {1'b0, READY_MARGIN_MV} >= {1'b0, limit});
        short_d = shutdown_n &&
                  ({1'b0, led_mv} + {1'b0, READY_MARGIN_MV} >= {1'b0, limit});
        drive_d = shutdown_n && !short_d &&
                  ((st_q == ST_FLASH) || (!flash_mode && torch_en));
        cur_d   = (st_q == ST_FLASH) ? regs_q.flash_cur : regs_q.torch_cur;
        if (!drive_d) begin
            cur_d = REG_CLEAR;
        end
    end

    logic        ready_q, short_q, drive_q;
    logic [7:0]  cur_q, rd_q;
    logic [12:0] limit_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ready_q <= 1'b0;
            short_q <= 1'b0;
            drive_q <= 1'b0;
            cur_q   <= '0;
            rd_q    <= '0;
            limit_q <= '0;
        end else begin
            ready_q <= ready_d;
            short_q <= short_d;
            drive_q <= drive_d;
            cur_q   <= cur_d;
            rd_q    <= rd_d;
            limit_q <= limit;
        end
    end

    assign supply_ready_flag    = ready_q;
    assign short_led_flag       = short_q;
    assign led_on               = {NUM_CHANNELS{drive_q}};
    assign led_sink_current     = cur_q;
    assign reg_rd_data          = rd_q;
    assign output_voltage_limit = limit_q;
    // straight from state: leads led_on by one cycle
    assign flash_active         = (st_q == ST_FLASH);

endmodule : flash_led_driver_control

// ===== verification/flash_led_chk.sv
`timescale 1ns/1ps
module flash_led_chk
    import flash_led_pkg::*;
(
    input wire logic                    clk_sys,
    input wire logic                    rst_n,
    input wire logic                    shutdown_n,
    input wire logic                    flash_trigger,
    input wire flash_led_pkg::reg_wr_t  reg_wr,
    input wire flash_led_pkg::reg_sel_t reg_rd_sel,
    input wire logic [7:0]              reg_rd_data,
    input wire logic [12:0]             vout_mv,
    input wire logic [12:0]             led_mv,
    input wire logic                    supply_ready_flag,
    input wire logic [12:0]             output_voltage_limit,
    input wire logic [NUM_CHANNELS-1:0] led_on,
    input wire logic [7:0]              led_sink_current,
    input wire logic                    flash_active,
    input wire logic                    short_led_flag
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // two quiet cycles so the registered flag has caught up, reset's tail left out
    a_ready_margin: assert property ($past(rst_n, 2) && $past(vout_mv, 2) == vout_mv
        && shutdown_n && $past(shutdown_n)
        && $past(output_voltage_limit, 2) == output_voltage_limit
        |-> supply_ready_flag == (14'(vout_mv) + 14'(READY_MARGIN_MV)
            >= 14'(output_voltage_limit)))
        else $error("ready flag wrong");
    a_short_detect: assert property ($past(rst_n, 2) && $past(led_mv, 2) == led_mv
        && shutdown_n && $past(shutdown_n)
        && $past(output_voltage_limit, 2) == output_voltage_limit
        |-> short_led_flag == (14'(led_mv) + 14'(READY_MARGIN_MV)
            >= 14'(output_voltage_limit)))
        else $error("short flag wrong");
    a_short_off: assert property (short_led_flag |-> led_on == '0)
        else $error("led lit while shorted");
    a_shut_dark: assert property (!shutdown_n
        |=> led_on == '0 && led_sink_current == 8'h00) else $error("led lit in shutdown");
    a_flash_start: assert property ($rose(flash_active)
        |-> $past(flash_trigger, 3) && !$past(flash_trigger, 4))
        else $error("flash start not on trigger edge");
    a_flash_lit: assert property ($rose(flash_active) && shutdown_n && !short_led_flag
        |=> led_on == '1) else $error("flash did not light");
    a_shut_frozen: assert property (!shutdown_n && $past(!shutdown_n)
        && $past(!shutdown_n, 2) && $stable(reg_rd_sel) |=> $stable(reg_rd_data))
        else $error("registers moved in shutdown");
    a_read_back: assert property ($past(reg_wr.wr) && $past(shutdown_n) && !reg_wr.wr
        && reg_rd_sel == $past(reg_wr.sel) |=> reg_rd_data == $past(reg_wr.data, 2))
        else $error("readback differs from write");
endmodule : flash_led_chk

// ===== verification/host_model.sv
`timescale 1ns/1ps
module host_model
    import flash_led_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic [7:0]        reg_rd_data,
    output flash_led_pkg::reg_wr_t  reg_wr,
    output flash_led_pkg::reg_sel_t reg_rd_sel,
    output logic                   flash_trigger
);
    initial begin
        reg_wr = '0;
        reg_rd_sel = REG_SEL_ONE;
        flash_trigger = 1'b0;
    end
    // one-cycle strobe, changed just after the edge
    task automatic write_reg(input reg_sel_t sel, input logic [7:0] data);
        @(posedge clk_sys) #1;
        reg_wr = '{wr: 1'b1, sel: sel, data: data};
        @(posedge clk_sys) #1;
        reg_wr.wr = 1'b0;
    endtask : write_reg
    task automatic read_reg(input reg_sel_t sel, output logic [7:0] data);
        @(posedge clk_sys) #1;
        reg_rd_sel = sel;
        repeat (2) @(posedge clk_sys);
        #1 data = reg_rd_data;
    endtask : read_reg
    task automatic set_trigger(input logic lvl);
        @(posedge clk_sys) #1;
        flash_trigger = lvl;
    endtask : set_trigger
endmodule : host_model

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
    import flash_led_pkg::*;
    logic clk_sys, rst_n, shutdown_n, torch_en, flash_trigger;
    logic supply_ready_flag, flash_active, short_led_flag;
    logic [12:0] vout_mv, led_mv, output_voltage_limit;
    logic [7:0] reg_rd_data, led_sink_current, rd;
    logic [NUM_CHANNELS-1:0] led_on;
    reg_wr_t reg_wr;
    reg_sel_t reg_rd_sel;
    int n_errors = 0;
    int cmp_count = 0;
    logic [7:0] img [4] = '{8'hE1, 8'hA0, 8'hFC, 8'h02};
    localparam logic [12:0] LIM = FLASH_BASE_MV + 13'h0005 * FLASH_STEP_MV;
    flash_led_driver_control dut_u (.clk_sys, .rst_n, .shutdown_n, .flash_trigger, .reg_wr,
        .reg_rd_sel, .reg_rd_data, .vout_mv, .led_mv, .torch_en, .supply_ready_flag,
        .output_voltage_limit, .led_on, .led_sink_current, .flash_active, .short_led_flag);
    host_model host_u (.clk_sys, .reg_rd_data, .reg_wr, .reg_rd_sel, .flash_trigger);
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic rd_chk(input reg_sel_t s, input logic [7:0] e);
        host_u.read_reg(s, rd);
        check("readback", {8'h00, rd}, {8'h00, e});
    endtask : rd_chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic summarize;
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        n_errors++;
        summarize();
    end
    initial begin
        {rst_n, torch_en, vout_mv, led_mv} = '0;
        shutdown_n = 1'b1;
        tick(5);
        rst_n = 1'b1;
        tick(2);
        check("limit", output_voltage_limit, TORCH_LIMIT_MV);
        for (int i = 0; i < 4; i++) host_u.write_reg(reg_sel_t'(i), img[i]);
        for (int i = 0; i < 4; i++) rd_chk(reg_sel_t'(i), img[i]);
        check("limit", output_voltage_limit, LIM);
        vout_mv = LIM - READY_MARGIN_MV;
        tick(3);
        check("ready", supply_ready_flag, 1);
        vout_mv = LIM - READY_MARGIN_MV - 13'h0001;
        tick(3);
        check("ready", supply_ready_flag, 0);
        // two synchroniser stages plus the state register: flash shows on the third edge
        host_u.set_trigger(1'b1);
        tick(2);
        check("flash", flash_active, 0);
        tick(1);
        check("flash", flash_active, 1);
        tick(1);
        check("led", led_on, 3'h7);
        check("current", led_sink_current, 8'hFC);
        led_mv = LIM - READY_MARGIN_MV;
        tick(3);
        check("short", short_led_flag, 1);
        check("led", led_on, 0);
        led_mv = '0;
        shutdown_n = 1'b0;
        host_u.write_reg(REG_SEL_TWO, 8'h00);
        tick(2);
        check("led", led_on, 0);
        check("flash", flash_active, 0);
        shutdown_n = 1'b1;
        host_u.set_trigger(1'b0);
        check("flash", flash_active, 0);
        rd_chk(REG_SEL_ONE, 8'hE1);
        rd_chk(REG_SEL_TWO, 8'hA0);
        host_u.write_reg(REG_SEL_ONE, 8'h01);
        torch_en = 1'b1;
        // a fresh trigger edge outside flash mode must not start a flash
        host_u.set_trigger(1'b1);
        tick(3);
        check("flash", flash_active, 0);
        check("current", led_sink_current, 8'h02);
        check("led", led_on, 3'h7);
        check("limit", output_voltage_limit, TORCH_LIMIT_MV);
        // retain bit now clear, so shutdown wipes the image
        shutdown_n = 1'b0;
        tick(3);
        shutdown_n = 1'b1;
        torch_en = 1'b0;
        for (int i = 0; i < 4; i++) rd_chk(reg_sel_t'(i), 8'h00);
        summarize();
    end
endmodule : tb
bind flash_led_driver_control flash_led_chk chk_u (.clk_sys, .rst_n, .shutdown_n, .flash_trigger,
    .reg_wr, .reg_rd_sel, .reg_rd_data, .vout_mv, .led_mv, .supply_ready_flag,
    .output_voltage_limit, .led_on, .led_sink_current, .flash_active, .short_led_flag);
